// [verilog/pcs_word_map.vh]
// register offsets, field positions, reset values and timing counts
// for the fabric word mapping block; definitions only
`ifndef PCS_WORD_MAP_VH
`define PCS_WORD_MAP_VH

// apb register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_MASK 8'h0c

// control register fields
`define CTRL_CODING_EN 0
`define CTRL_DOUBLE_WIDTH 1
`define CTRL_BYTE_SERIAL 2
`define CTRL_WIDTH 3
`define CTRL_RESET 3'h1

// status register fields
`define STAT_REF_LOCK 0
`define STAT_TX_CAL_BUSY 1
`define STAT_RX_CAL_BUSY 2
`define STAT_SLIP_ACTIVE 3
`define STAT_CLK_STRETCH 4

// interrupt event bits
`define EV_LOCK_GAINED 0
`define EV_LOCK_LOST 1
`define EV_SLIP_STEP 2
`define EV_TX_CAL_DONE 3
`define EV_RX_CAL_DONE 4
`define EV_CODE_ERR 5
`define EV_WIDTH 6
`define INT_MASK_RESET 6'h00

// transmit word layout
`define TX_STRIDE 11
`define TX_CTRL_BIT 8
`define TX_FORCE_BIT 9
`define TX_DISP_BIT 10

// receive word layout
`define RX_STRIDE 16
`define RX_CTRL_BIT 8
`define RX_ERR_BIT 9
`define RX_SYNC_BIT 10
`define RX_DERR_BIT 11
`define RX_PAT_BIT 12
`define RX_RM_LO 13
`define RX_RDISP_BIT 15

// rate match events from the pcs, 3 bits per lane
`define RM_NORMAL 3'h0
`define RM_DELETE 3'h1
`define RM_INSERT 3'h2
`define RM_UNDERFLOW 3'h3
`define RM_OVERFLOW 3'h4

// rate match codes on the fabric word
`define RMC_NORMAL 2'h0
`define RMC_DELETE 2'h1
`define RMC_INSERT 2'h2
`define RMC_UNDER_OVER 2'h3
`define RM_UNDERFLOW_MARK 9'h1fe

// bit slip sequence
`define SLIP_SKIP_BITS 2'h1
`define SLIP_STALL_CYCLES 2'h2
`define SLIP_STRETCH_UI 2'h2

`endif

// [verilog/tx_word_unpack.v]
// splits the 64-bit transmit fabric word into up to four 11-bit lanes
// assumes the lane valid mask comes from the control decode in the top
`timescale 1ns/1ps
`include "pcs_word_map.vh"

module tx_word_unpack #(
  parameter LANES = 4
) (
  input wire clk,
  input wire reset,
  input wire [63:0] fabric_word,
  input wire coding_en,
  input wire [LANES-1:0] lane_mask,
  output reg [LANES*10-1:0] lane_data,
  output reg [LANES-1:0] lane_ctrl,
  output reg [LANES-1:0] lane_force_disp,
  output reg [LANES-1:0] lane_disp_neg,
  output reg [LANES-1:0] lane_valid
);

  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1) begin : lane
      // bits above the last lane's 11-bit field are never looked at
      wire [10:0] w = fabric_word[i*`TX_STRIDE +: 11];
      always @(posedge clk) begin
        if (reset) begin
          lane_data[i*10 +: 10] <= 10'h000;
          lane_ctrl[i] <= 1'b0;
          lane_force_disp[i] <= 1'b0;
          lane_disp_neg[i] <= 1'b0;
          lane_valid[i] <= 1'b0;
        end else begin
          lane_valid[i] <= lane_mask[i];
          if (!lane_mask[i]) begin
            lane_data[i*10 +: 10] <= 10'h000;
            lane_ctrl[i] <= 1'b0;
            lane_force_disp[i] <= 1'b0;
            lane_disp_neg[i] <= 1'b0;
          end else if (coding_en) begin
            lane_data[i*10 +: 10] <= {2'h0, w[7:0]};
            lane_ctrl[i] <= w[`TX_CTRL_BIT];
            lane_force_disp[i] <= w[`TX_FORCE_BIT];
            // disparity field only counts while forcing is on
            lane_disp_neg[i] <= w[`TX_FORCE_BIT] & w[`TX_DISP_BIT];
          end else begin
            lane_data[i*10 +: 10] <= w[9:0];
            lane_ctrl[i] <= 1'b0;
            lane_force_disp[i] <= 1'b0;
            lane_disp_neg[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule

// [verilog/rx_word_pack.v]
// packs per-lane receive data and status into the 64-bit fabric word
// assumes status inputs are already aligned to the lane data
`timescale 1ns/1ps
`include "pcs_word_map.vh"

module rx_word_pack #(
  parameter LANES = 4
) (
  input wire clk,
  input wire reset,
  input wire coding_en,
  input wire [LANES-1:0] lane_mask,
  input wire [LANES*10-1:0] lane_data,
  input wire [LANES-1:0] lane_ctrl,
  input wire [LANES-1:0] lane_code_err,
  input wire [LANES-1:0] lane_sync,
  input wire [LANES-1:0] lane_disp_err,
  input wire [LANES-1:0] lane_pattern,
  input wire [LANES*3-1:0] lane_rate_event,
  input wire [LANES-1:0] lane_run_disp,
  output reg [LANES*16-1:0] fabric_word
);

  // rate match event to the two-bit field, per coding mode
  function [1:0] rm_code;
    input [2:0] ev;
    input coding;
    begin
      case (ev)
        `RM_DELETE: rm_code = `RMC_DELETE;
        `RM_INSERT: rm_code = `RMC_INSERT;
        `RM_UNDERFLOW: rm_code = coding ? `RMC_UNDER_OVER : `RMC_INSERT;
        `RM_OVERFLOW: rm_code = coding ? `RMC_NORMAL : `RMC_UNDER_OVER;
        default: rm_code = `RMC_NORMAL;
      endcase
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1) begin : lane
      wire [2:0] ev = lane_rate_event[i*3 +: 3];
      wire under_raw = !coding_en && (ev == `RM_UNDERFLOW);
      reg [15:0] w;
      always @* begin
        w = 16'h0000;
        if (coding_en) begin
          w[7:0] = lane_data[i*10 +: 8];
          w[`RX_CTRL_BIT] = lane_ctrl[i];
          w[`RX_ERR_BIT] = lane_code_err[i];
        end else if (under_raw) begin
          w[8:0] = `RM_UNDERFLOW_MARK;
        end else begin
          w[9:0] = lane_data[i*10 +: 10];
        end
        w[`RX_SYNC_BIT] = lane_sync[i];
        w[`RX_DERR_BIT] = lane_disp_err[i];
        w[`RX_PAT_BIT] = lane_pattern[i];
        w[`RX_RM_LO +: 2] = rm_code(ev, coding_en);
        w[`RX_RDISP_BIT] = lane_run_disp[i];
      end
      always @(posedge clk) begin
        if (reset)
          fabric_word[i*16 +: 16] <= 16'h0000;
        else if (lane_mask[i])
          fabric_word[i*16 +: 16] <= w;
        else
          fabric_word[i*16 +: 16] <= 16'h0000;
      end
    end
  endgenerate

endmodule

// [verilog/pcs_fabric_word_mapping.v]
// top of the fabric word mapping block: apb registers, interrupt,
// lock and calibration flags, bit slip sequencer, tx and rx mappers
// assumes one clock, synchronous active high reset, inputs synchronous
//
// Notes on behaviour
// - The reference lock flag is high while the recovery loop is locked.
// - A slip request alternately skips one serial bit and stalls 2 cycles.
// - A slip may stretch one parallel clock period by up to 2 UI.
// - TX cal busy is high in initial cal or reconfig reset, not manual cal.
// - RX cal busy is high in initial cal or reconfig reset, not manual cal.
// - The TX fabric word is 64 bits and its top 20 bits are ignored.
// - With coding on, TX bit 9 forces disparity chosen by bit 10, 1 negative.
// - With coding off, TX bits 9:0 are raw data and bit 10 is unused.
// - Valid TX words sit at an 11-bit stride chosen by width and serializer.
// - With coding on, RX bits 7:0 data, bit 8 control, bit 9 code error.
// - RX bits 10, 11, 12, 15: sync, disparity error, pattern, disparity.
// - With coding on, RX bits 14:13 give normal, delete, insert, underflow.
// - Coding off: RX bits 14:13 give insert or underflow mark, overflow.
// - Valid RX words sit at a 16-bit stride chosen by width and serializer.
`timescale 1ns/1ps
`include "pcs_word_map.vh"

module pcs_fabric_word_mapping #(
  parameter LANES = 4
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  output reg IRQ,
  input wire [63:0] TX_FABRIC_WORD,
  output wire [LANES*10-1:0] TX_LANE_DATA,
  output wire [LANES-1:0] TX_LANE_CTRL,
  output wire [LANES-1:0] TX_FORCE_DISP,
  output wire [LANES-1:0] TX_DISP_NEG,
  output wire [LANES-1:0] TX_LANE_VALID,
  input wire [LANES*10-1:0] RX_LANE_DATA,
  input wire [LANES-1:0] RX_LANE_CTRL,
  input wire [LANES-1:0] RX_CODE_ERR,
  input wire [LANES-1:0] RX_SYNC,
  input wire [LANES-1:0] RX_DISP_ERR,
  input wire [LANES-1:0] RX_PATTERN,
  input wire [LANES*3-1:0] RX_RATE_EVENT,
  input wire [LANES-1:0] RX_RUN_DISP,
  output wire [LANES*16-1:0] RX_FABRIC_WORD,
  input wire CDR_LOCKED,
  output reg CDR_REF_LOCK_FLAG,
  input wire CLK_SLIP_REQ,
  output reg SER_SKIP_BIT,
  output reg SER_CLK_STALL,
  output reg PAR_CLK_STRETCH,
  input wire TX_CAL_INIT,
  input wire RX_CAL_INIT,
  input wire MANUAL_CAL,
  input wire RECONF_RESET,
  output reg TX_CAL_BUSY,
  output reg RX_CAL_BUSY
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SKIP = 2'h1;
  localparam ST_STALL = 2'h2;

  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [`EV_WIDTH-1:0] int_status;
  reg [`EV_WIDTH-1:0] int_mask;
  reg [1:0] slip_state;
  reg [1:0] next_slip_state;
  reg [1:0] slip_count;
  reg [1:0] next_slip_count;
  reg lock_prev;
  reg tx_busy_prev;
  reg rx_busy_prev;
  reg [`EV_WIDTH-1:0] events;
  reg [31:0] next_rdata;
  reg next_err;
  reg [LANES-1:0] lane_mask;

  wire coding_en = ctrl[`CTRL_CODING_EN];
  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE && PREADY;
  wire wr = access && PWRITE && !PSLVERR;
  wire [`EV_WIDTH-1:0] w1c = (wr && PADDR == `OFS_INT_STATUS) ?
    PWDATA[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

  // which of the four word slots carry data for a width setting
  function [3:0] slot_mask;
    input double_width;
    input byte_serial;
    begin
      case ({double_width, byte_serial})
        2'b00: slot_mask = 4'h1;
        2'b01: slot_mask = 4'h5;
        2'b10: slot_mask = 4'h3;
        default: slot_mask = 4'hf;
      endcase
    end
  endfunction

  // register address decode for the error answer; read data decodes with its own case
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `OFS_CTRL) || (addr == `OFS_STATUS) ||
        (addr == `OFS_INT_STATUS) || (addr == `OFS_INT_MASK);
    end
  endfunction

  always @* begin
    lane_mask = slot_mask(ctrl[`CTRL_DOUBLE_WIDTH],
      ctrl[`CTRL_BYTE_SERIAL]);
  end

  // apb slave: answer in the first access cycle, data latched at setup
  always @* begin
    next_rdata = 32'h00000000;
    next_err = !mapped(PADDR);
    case (PADDR)
      `OFS_CTRL: next_rdata[`CTRL_WIDTH-1:0] = ctrl;
      `OFS_STATUS: begin
        next_rdata[`STAT_REF_LOCK] = CDR_REF_LOCK_FLAG;
        next_rdata[`STAT_TX_CAL_BUSY] = TX_CAL_BUSY;
        next_rdata[`STAT_RX_CAL_BUSY] = RX_CAL_BUSY;
        next_rdata[`STAT_SLIP_ACTIVE] = slip_state != ST_IDLE;
        next_rdata[`STAT_CLK_STRETCH] = PAR_CLK_STRETCH;
      end
      `OFS_INT_STATUS: next_rdata[`EV_WIDTH-1:0] = int_status;
      `OFS_INT_MASK: next_rdata[`EV_WIDTH-1:0] = int_mask;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h00000000 : next_rdata;
        PSLVERR <= next_err;
      end else if (access) begin
        PRDATA <= 32'h00000000;
        PSLVERR <= 1'b0;
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl <= `CTRL_RESET;
      int_mask <= `INT_MASK_RESET;
    end else if (wr) begin
      if (PADDR == `OFS_CTRL)
        ctrl <= PWDATA[`CTRL_WIDTH-1:0];
      if (PADDR == `OFS_INT_MASK)
        int_mask <= PWDATA[`EV_WIDTH-1:0];
    end
  end

  // lock and calibration flags
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      CDR_REF_LOCK_FLAG <= 1'b0;
      TX_CAL_BUSY <= 1'b1;
      RX_CAL_BUSY <= 1'b1;
      lock_prev <= 1'b0;
      tx_busy_prev <= 1'b1;
      rx_busy_prev <= 1'b1;
    end else begin
      CDR_REF_LOCK_FLAG <= CDR_LOCKED;
      // a manual re-run of calibration never raises the busy flags
      TX_CAL_BUSY <= (TX_CAL_INIT && !MANUAL_CAL) || RECONF_RESET;
      RX_CAL_BUSY <= (RX_CAL_INIT && !MANUAL_CAL) || RECONF_RESET;
      lock_prev <= CDR_REF_LOCK_FLAG;
      tx_busy_prev <= TX_CAL_BUSY;
      rx_busy_prev <= RX_CAL_BUSY;
    end
  end

  // slip sequencer: one skip step, then a two-cycle stall, while requested
  always @* begin
    next_slip_state = slip_state;
    next_slip_count = slip_count;
    case (slip_state)
      ST_IDLE: begin
        if (CLK_SLIP_REQ) begin
          next_slip_state = ST_SKIP;
          next_slip_count = `SLIP_SKIP_BITS;
        end
      end
      ST_SKIP: begin
        if (slip_count == 2'h1) begin
          next_slip_state = ST_STALL;
          next_slip_count = `SLIP_STALL_CYCLES;
        end else begin
          next_slip_count = slip_count - 2'h1;
        end
      end
      ST_STALL: begin
        if (slip_count == 2'h1) begin
          next_slip_state = CLK_SLIP_REQ ? ST_SKIP : ST_IDLE;
          next_slip_count = `SLIP_SKIP_BITS;
        end else begin
          next_slip_count = slip_count - 2'h1;
        end
      end
      default: begin
        next_slip_state = ST_IDLE;
        next_slip_count = 2'h0;
      end
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      slip_state <= ST_IDLE;
      slip_count <= 2'h0;
      SER_SKIP_BIT <= 1'b0;
      SER_CLK_STALL <= 1'b0;
      PAR_CLK_STRETCH <= 1'b0;
    end else begin
      slip_state <= next_slip_state;
      slip_count <= next_slip_count;
      SER_SKIP_BIT <= next_slip_state == ST_SKIP;
      SER_CLK_STALL <= next_slip_state == ST_STALL;
      // each stall cycle lengthens the recovered parallel period by one UI
      PAR_CLK_STRETCH <= next_slip_state == ST_STALL;
    end
  end

  // events, sticky status with write-one-to-clear; a new event wins
  always @* begin
    events = {`EV_WIDTH{1'b0}};
    events[`EV_LOCK_GAINED] = CDR_REF_LOCK_FLAG && !lock_prev;
    events[`EV_LOCK_LOST] = !CDR_REF_LOCK_FLAG && lock_prev;
    events[`EV_SLIP_STEP] = slip_state == ST_STALL && slip_count == 2'h1;
    events[`EV_TX_CAL_DONE] = tx_busy_prev && !TX_CAL_BUSY;
    events[`EV_RX_CAL_DONE] = rx_busy_prev && !RX_CAL_BUSY;
    events[`EV_CODE_ERR] = coding_en && |(RX_CODE_ERR & lane_mask);
  end

  always @(posedge SYS_CLK) begin
    if (RESET) begin
      int_status <= {`EV_WIDTH{1'b0}};
      IRQ <= 1'b0;
    end else begin
      int_status <= (int_status & ~w1c) | events;
      IRQ <= |(((int_status & ~w1c) | events) & int_mask);
    end
  end

  tx_word_unpack #(
    .LANES(LANES)
  ) u_tx (
    .clk(SYS_CLK),
    .reset(RESET),
    .fabric_word(TX_FABRIC_WORD),
    .coding_en(coding_en),
    .lane_mask(lane_mask),
    .lane_data(TX_LANE_DATA),
    .lane_ctrl(TX_LANE_CTRL),
    .lane_force_disp(TX_FORCE_DISP),
    .lane_disp_neg(TX_DISP_NEG),
    .lane_valid(TX_LANE_VALID)
  );

  rx_word_pack #(
    .LANES(LANES)
  ) u_rx (
    .clk(SYS_CLK),
    .reset(RESET),
    .coding_en(coding_en),
    .lane_mask(lane_mask),
    .lane_data(RX_LANE_DATA),
    .lane_ctrl(RX_LANE_CTRL),
    .lane_code_err(RX_CODE_ERR),
    .lane_sync(RX_SYNC),
    .lane_disp_err(RX_DISP_ERR),
    .lane_pattern(RX_PATTERN),
    .lane_rate_event(RX_RATE_EVENT),
    .lane_run_disp(RX_RUN_DISP),
    .fabric_word(RX_FABRIC_WORD)
  );

endmodule

// [tb/fabric_side.sv]
// fabric logic model that presents transmit words to the block
// assumes one clock shared with the block under test
`timescale 1ns/1ps
module fabric_side (
  input wire clk,
  input wire cal_busy,
  input wire [63:0] word_req,
  output reg [63:0] tx_word = 64'h0
);
  // channel word held at zero while transmit calibration is busy
  always @(posedge clk) begin
    tx_word <= cal_busy ? 64'h0 : word_req;
  end
endmodule

// [tb/pcs_fabric_word_mapping_monitor.sv]
// checker for apb handshake, lock and cal flags, slip and word mapping
// assumes SYS_CLK and synchronous active high RESET of the top
`timescale 1ns/1ps
module pcs_map_monitor #(
  parameter LANES = 4
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire CDR_LOCKED,
  input wire CDR_REF_LOCK_FLAG,
  input wire CLK_SLIP_REQ,
  input wire SER_SKIP_BIT,
  input wire SER_CLK_STALL,
  input wire PAR_CLK_STRETCH,
  input wire TX_CAL_INIT,
  input wire RX_CAL_INIT,
  input wire MANUAL_CAL,
  input wire RECONF_RESET,
  input wire TX_CAL_BUSY,
  input wire RX_CAL_BUSY,
  input wire [LANES-1:0] TX_LANE_VALID,
  input wire [LANES-1:0] TX_FORCE_DISP,
  input wire [LANES-1:0] TX_DISP_NEG,
  input wire [LANES-1:0] RX_SYNC,
  input wire [LANES-1:0] RX_DISP_ERR,
  input wire [LANES*16-1:0] RX_FABRIC_WORD
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence idle_req_s;
    CLK_SLIP_REQ && !SER_SKIP_BIT && !SER_CLK_STALL;
  endsequence
  sequence stall_s;
    (SER_CLK_STALL && PAR_CLK_STRETCH && !SER_SKIP_BIT) [*2];
  endsequence
  apb_ready_a: assert property (setup_s |=> PREADY ##1 !PREADY)
    else $error("pready not one cycle after setup");
  slverr_a: assert property (PSLVERR |-> PREADY)
    else $error("pslverr without pready");
  lock_follow_a: assert property (!$past(RESET) |->
    CDR_REF_LOCK_FLAG == $past(CDR_LOCKED))
    else $error("lock flag does not follow cdr lock");
  tx_busy_a: assert property (!$past(RESET) |-> TX_CAL_BUSY ==
    (($past(TX_CAL_INIT) && !$past(MANUAL_CAL)) || $past(RECONF_RESET)))
    else $error("tx cal busy wrong");
  rx_busy_a: assert property (!$past(RESET) |-> RX_CAL_BUSY ==
    (($past(RX_CAL_INIT) && !$past(MANUAL_CAL)) || $past(RECONF_RESET)))
    else $error("rx cal busy wrong");
  slip_start_a: assert property (idle_req_s |=> SER_SKIP_BIT)
    else $error("slip request not taken");
  slip_steps_a: assert property (SER_SKIP_BIT |=> stall_s)
    else $error("skip not followed by two stall cycles");
  tx_mask_a: assert property (!$past(RESET) |->
    TX_LANE_VALID inside {4'h1, 4'h3, 4'h5, 4'hf})
    else $error("tx lane mask illegal");
  tx_refuse_a: assert property (((TX_FORCE_DISP | TX_DISP_NEG) &
    ~TX_LANE_VALID) == 0 && (TX_DISP_NEG & ~TX_FORCE_DISP) == 0)
    else $error("disparity flags on refused lane");
  rx_status_a: assert property (!$past(RESET) |->
    RX_FABRIC_WORD[10] == $past(RX_SYNC[0]) &&
    RX_FABRIC_WORD[11] == $past(RX_DISP_ERR[0]))
    else $error("rx sync or disparity error misplaced");
endmodule
bind pcs_fabric_word_mapping pcs_map_monitor #(.LANES(LANES)) mon_u (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CDR_LOCKED(CDR_LOCKED),
  .CDR_REF_LOCK_FLAG(CDR_REF_LOCK_FLAG), .CLK_SLIP_REQ(CLK_SLIP_REQ),
  .SER_SKIP_BIT(SER_SKIP_BIT), .SER_CLK_STALL(SER_CLK_STALL),
  .PAR_CLK_STRETCH(PAR_CLK_STRETCH), .TX_CAL_INIT(TX_CAL_INIT),
  .RX_CAL_INIT(RX_CAL_INIT), .MANUAL_CAL(MANUAL_CAL),
  .RECONF_RESET(RECONF_RESET), .TX_CAL_BUSY(TX_CAL_BUSY),
  .RX_CAL_BUSY(RX_CAL_BUSY), .TX_LANE_VALID(TX_LANE_VALID),
  .TX_FORCE_DISP(TX_FORCE_DISP), .TX_DISP_NEG(TX_DISP_NEG),
  .RX_SYNC(RX_SYNC), .RX_DISP_ERR(RX_DISP_ERR),
  .RX_FABRIC_WORD(RX_FABRIC_WORD));

// [tb/pcs_fabric_word_mapping_tb.sv]
// self-checking bench for the fabric word mapping block
// assumes the fabric model and the bound checker are compiled first
`timescale 1ns/1ps
module pcs_fabric_word_mapping_tb;
  logic SYS_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, er;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, rd;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, IRQ, CDR_REF_LOCK_FLAG, SER_SKIP_BIT;
  wire SER_CLK_STALL, PAR_CLK_STRETCH, TX_CAL_BUSY, RX_CAL_BUSY;
  logic [63:0] word_req = 0, t, re;
  wire [63:0] TX_FABRIC_WORD, RX_FABRIC_WORD;
  wire [39:0] TX_LANE_DATA;
  wire [3:0] TX_LANE_CTRL, TX_FORCE_DISP, TX_DISP_NEG, TX_LANE_VALID;
  logic [39:0] RX_LANE_DATA = 0, d;
  logic [3:0] RX_LANE_CTRL = 0, RX_CODE_ERR = 0, RX_SYNC = 0;
  logic [3:0] RX_DISP_ERR = 0, RX_PATTERN = 0, RX_RUN_DISP = 0;
  logic [11:0] RX_RATE_EVENT = 0, ev;
  logic CDR_LOCKED = 0, CLK_SLIP_REQ = 0, TX_CAL_INIT = 1;
  logic RX_CAL_INIT = 1, MANUAL_CAL = 0, RECONF_RESET = 0;
  logic [2:0] c;
  logic [3:0] m, ct, fo, ng;
  logic [10:0] w;
  int i, l, n_fail = 0, checks_done = 0;
  // each row: control value beside the lane mask it should give
  logic [6:0] rows [10] = '{7'h01, 7'h11, 7'h23, 7'h33, 7'h45,
    7'h55, 7'h6f, 7'h7f, 7'h01, 7'h11};
  pcs_fabric_word_mapping #(.LANES(4)) dut_u (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .TX_FABRIC_WORD(TX_FABRIC_WORD), .TX_LANE_DATA(TX_LANE_DATA),
    .TX_LANE_CTRL(TX_LANE_CTRL), .TX_FORCE_DISP(TX_FORCE_DISP),
    .TX_DISP_NEG(TX_DISP_NEG), .TX_LANE_VALID(TX_LANE_VALID),
    .RX_LANE_DATA(RX_LANE_DATA), .RX_LANE_CTRL(RX_LANE_CTRL),
    .RX_CODE_ERR(RX_CODE_ERR), .RX_SYNC(RX_SYNC),
    .RX_DISP_ERR(RX_DISP_ERR), .RX_PATTERN(RX_PATTERN),
    .RX_RATE_EVENT(RX_RATE_EVENT), .RX_RUN_DISP(RX_RUN_DISP),
    .RX_FABRIC_WORD(RX_FABRIC_WORD), .CDR_LOCKED(CDR_LOCKED),
    .CDR_REF_LOCK_FLAG(CDR_REF_LOCK_FLAG), .CLK_SLIP_REQ(CLK_SLIP_REQ),
    .SER_SKIP_BIT(SER_SKIP_BIT), .SER_CLK_STALL(SER_CLK_STALL),
    .PAR_CLK_STRETCH(PAR_CLK_STRETCH), .TX_CAL_INIT(TX_CAL_INIT),
    .RX_CAL_INIT(RX_CAL_INIT), .MANUAL_CAL(MANUAL_CAL),
    .RECONF_RESET(RECONF_RESET), .TX_CAL_BUSY(TX_CAL_BUSY),
    .RX_CAL_BUSY(RX_CAL_BUSY));
  fabric_side fab_u (.clk(SYS_CLK), .cal_busy(TX_CAL_BUSY),
    .word_req(word_req), .tx_word(TX_FABRIC_WORD));
  function automatic [63:0] rx_exp(input [2:0] c, input [63:0] t,
    input [11:0] ev, input [3:0] m);
    logic [15:0] x;
    logic [2:0] e;
    logic [1:0] rc;
    begin
      rx_exp = 0;
      for (int i = 0; i < 4; i++) begin
        e = ev[3*i+:3];
        rc = e[1:0];
        if (e == 3'h4) rc = c[0] ? 2'h0 : 2'h3;
        else if (e == 3'h3 && !c[0]) rc = 2'h2;
        x = {t[60+i], rc, t[56+i], t[52+i], t[48+i],
          c[0] ? {t[44+i], t[40+i], t[10*i+:8]} : t[10*i+:10]};
        if (e == 3'h3 && !c[0]) x[9:0] = 10'h1fe;
        if (m[i]) rx_exp[16*i+:16] = x;
      end
    end
  endfunction
  task check(input string nm, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    begin
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= v;
      @(posedge SYS_CLK);
      PENABLE <= 1;
      n = 0;
      @(posedge SYS_CLK);
      while (PREADY !== 1'b1 && n < 50) begin
        n++;
        @(posedge SYS_CLK);
      end
      if (n == 50) n_fail++;
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      // one idle cycle so the next call never re-drives psel in this step
      @(posedge SYS_CLK);
    end
  endtask
  task settle(input int k);
    repeat (k) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #2.5 SYS_CLK = ~SYS_CLK;
  initial begin
    #20000;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge SYS_CLK);
    check("rst_out", {TX_CAL_BUSY, RX_CAL_BUSY, PREADY, IRQ}, 4'hc);
    RESET <= 0;
    @(posedge SYS_CLK);
    apb(0, 8'h00, 0);
    check("ctrl_rst", rd, 1);
    apb(0, 8'h0c, 0);
    check("mask_rst", rd, 0);
    apb(0, 8'h10, 0);
    check("unmapped", {er, rd}, 33'h100000000);
    check("busy_init", {TX_CAL_BUSY, RX_CAL_BUSY}, 2'h3);
    MANUAL_CAL <= 1;
    settle(2);
    check("busy_manual", {TX_CAL_BUSY, RX_CAL_BUSY}, 2'h0);
    @(posedge SYS_CLK);
    {MANUAL_CAL, TX_CAL_INIT, RX_CAL_INIT, RECONF_RESET} <= 4'h1;
    settle(2);
    check("busy_reconf", {TX_CAL_BUSY, RX_CAL_BUSY}, 2'h3);
    @(posedge SYS_CLK);
    RECONF_RESET <= 0;
    settle(2);
    @(posedge SYS_CLK);
    for (i = 0; i < 10; i++) begin
      {c, m} = rows[i];
      t = 64'h9e3779b97f4a7c15 * (i + 1);
      apb(1, 8'h00, {29'h0, c});
      word_req <= t;
      RX_LANE_DATA <= t[39:0];
      {RX_RUN_DISP, RX_PATTERN, RX_DISP_ERR, RX_SYNC, RX_CODE_ERR,
        RX_LANE_CTRL} <= t[63:40];
      {d, ct, fo, ng} = 0;
      for (l = 0; l < 4; l++) begin
        ev[3*l+:3] = 3'((i + l) % 5);
        w = t[11*l+:11];
        if (m[l]) begin
          d[10*l+:10] = c[0] ? {2'h0, w[7:0]} : w[9:0];
          {ct[l], fo[l], ng[l]} = {3{c[0]}} & {w[8], w[9], w[9] & w[10]};
        end
      end
      RX_RATE_EVENT <= ev;
      settle(2);
      check("tx_valid", TX_LANE_VALID, m);
      check("tx_data", TX_LANE_DATA, d);
      check("tx_disp", {TX_FORCE_DISP, TX_DISP_NEG}, {fo, ng});
      check("tx_ctrl", TX_LANE_CTRL, ct);
      re = rx_exp(c, t, ev, m);
      check("rx_word", RX_FABRIC_WORD, re);
      @(posedge SYS_CLK);
    end
    RX_CODE_ERR <= 0;
    apb(1, 8'h08, 32'h3f);
    apb(0, 8'h08, 0);
    check("int_clear", {IRQ, rd}, 0);
    apb(1, 8'h0c, 1);
    CDR_LOCKED <= 1;
    settle(3);
    check("irq_lock", {IRQ, CDR_REF_LOCK_FLAG}, 2'h3);
    @(posedge SYS_CLK);
    apb(0, 8'h04, 0);
    check("stat_lock", rd[0], 1);
    apb(1, 8'h08, 1);
    CDR_LOCKED <= 0;
    repeat (3) @(posedge SYS_CLK);
    apb(0, 8'h08, 0);
    check("int_masked", {IRQ, rd}, 2);
    CLK_SLIP_REQ <= 1;
    repeat (6) @(posedge SYS_CLK);
    CLK_SLIP_REQ <= 0;
    repeat (8) @(posedge SYS_CLK);
    apb(0, 8'h08, 0);
    check("slip_event", rd[2], 1);
    // reset again in mid-run: flags back to busy, lanes cleared
    RESET <= 1;
    repeat (2) @(posedge SYS_CLK);
    check("rst_mid", {TX_CAL_BUSY, RX_CAL_BUSY, TX_LANE_VALID}, 6'h30);
    RESET <= 0;
    @(posedge SYS_CLK);
    apb(0, 8'h00, 0);
    check("ctrl_mid", rd, 1);
    print_verdict;
  end
endmodule
